// ==== logic/crst_pkg.sv ====
// package of constants for the cache/memory controller reset block
package crst_pkg;
    // =========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SYNC_STAGES = 2;
    localparam int AGENT_WAIT_CYC = 10;
    localparam int POWERUP_CYC = 20;
    localparam int FORCE_REF_WAIT_CYC = 10;
    // one interval unit is 64 memory clocks, 32 system clocks
    localparam int MEMORY_CLOCK_PER_UNIT = 64;
    localparam int SYSCLK_PER_UNIT = MEMORY_CLOCK_PER_UNIT / 2;
    localparam int IVL_W = 8;
    localparam int CNT_W = 16;
    localparam logic [IVL_W-1:0] IVL_RESET = 8'h01;
    localparam int PD_BITS = 8;
    localparam logic [7:0] PD_CNT_RESET = 8'h00;
    typedef enum logic [1:0] {
        CRST_PD_IDLE = 2'b00,
        CRST_PD_SHIFT = 2'b01,
        CRST_PD_DONE = 2'b11
    } crst_pd_state_t;
endpackage

// ==== logic/crst_ref_if.sv ====
// interface carrying refresh requests between refresh timer and top
`timescale 1ns/10ps
`default_nettype none
interface crst_ref_if;
    logic run;
    logic force_req;
    logic ref_pulse;
    logic force_busy;
    logic [7:0] interval;
    modport timer (input run, input force_req, input interval,
        output ref_pulse, output force_busy);
    modport ctl (output run, output force_req, output interval,
        input ref_pulse, input force_busy);
endinterface
`default_nettype wire

// ==== logic/crst_ref_timer.sv ====
// refresh timer: periodic and forced refresh pulses
`timescale 1ns/10ps
`default_nettype none
module crst_ref_timer (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // refresh link
    crst_ref_if.timer ref_b
);
    import crst_pkg::*;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic busy;
    logic next_busy;
    logic pulse;
    logic next_pulse;
    logic [CNT_W-1:0] period;

    // =========================================================
    // period and counter
    always_comb begin
        period = CNT_W'(ref_b.interval) * CNT_W'(SYSCLK_PER_UNIT);
        if (period == '0) begin
            period = CNT_W'(SYSCLK_PER_UNIT);
        end
        next_count = count;
        next_pulse = 1'b0;
        next_busy = busy;
        if (!ref_b.run) begin
            next_count = '0;
            next_busy = 1'b0;
        end else if (busy) begin
            // a forced refresh is one pulse; busy drops in the same cycle
            next_pulse = 1'b1;
            next_busy = 1'b0;
            next_count = '0;
        end else if (count >= period - CNT_W'(1)) begin
            next_pulse = 1'b1;
            next_count = '0;
        end else begin
            next_count = count + CNT_W'(1);
        end
        if (ref_b.run && ref_b.force_req && !busy) begin
            next_busy = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count <= '0;
            busy <= 1'b0;
            pulse <= 1'b0;
        end else begin
            count <= next_count;
            busy <= next_busy;
            pulse <= next_pulse;
        end
    end

    assign ref_b.ref_pulse = pulse;
    assign ref_b.force_busy = busy;

    // =========================================================
    // check helper: clocks since the last pulse, kept apart from count
    // so that a wrong period in the counter logic shows up
    logic [5:0] gap;
    logic [5:0] next_gap;
    always_comb begin
        next_gap = gap;
        if (!ref_b.run) begin
            next_gap = 6'h00;
        end else if (pulse) begin
            next_gap = 6'h01;
        end else if (gap != 6'h3f) begin
            next_gap = gap + 6'h01;
        end
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gap <= 6'h00;
        end else begin
            gap <= next_gap;
        end
    end

    // =========================================================
    // checks
    // interval may change at any time, so the check looks one step ahead
    property p_period;
        @(posedge clk_i) disable iff (!reset_n_i)
        (ref_b.run && ref_b.interval == IVL_RESET && !busy && !pulse &&
            gap == 6'(SYSCLK_PER_UNIT - 1))
        |=> pulse;
    endproperty
    a_period: assert property (p_period)
        else $error("refresh period not 32 clocks");

    property p_force;
        @(posedge clk_i) disable iff (!reset_n_i)
        (ref_b.run && ref_b.force_req && !busy) |=> busy ##1 pulse;
    endproperty
    a_force: assert property (p_force)
        else $error("forced refresh did not complete");
endmodule
`default_nettype wire

// ==== logic/crst_reset_init.sv ====
// top: reset synchroniser, reset pin states, refresh and presence start
`timescale 1ns/10ps
`default_nettype none
module crst_reset_init #(
    parameter int PD_LEN = crst_pkg::PD_BITS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // test float-all, active low
    input wire logic float_all_n_i,
    // refresh control
    input wire logic [crst_pkg::IVL_W-1:0] ref_interval_i,
    input wire logic force_ref_i,
    output logic force_ref_busy_o,
    output logic refresh_o,
    output logic [7:0] refresh_count_o,
    // internal reset
    output logic int_reset_n_o,
    output logic agents_ok_o,
    // cache data and tag output enables
    output logic cache_data_out_en_ctl_o,
    output logic tag_out_en_ctl_o,
    output logic cache_data_out_en_ctl_oe_o,
    output logic tag_out_en_ctl_oe_o,
    // memory bus drive control
    output logic mem_bus_drive_ctl_o,
    output logic mem_bus_drive_ctl_oe_o,
    // normal-mode output request and bus drive
    input wire logic core_out_i,
    input wire logic core_bus_drive_i,
    output logic core_out_o,
    output logic core_out_oe_o,
    output logic core_bus_oe_o,
    // presence detect
    input wire logic pd_data_i,
    output logic pd_clk_o,
    output logic pd_load_n_o,
    output logic pd_done_o,
    output logic [crst_pkg::PD_BITS-1:0] pd_value_o
);
    import crst_pkg::*;

    // =========================================================
    // internal reset synchroniser
    logic [SYNC_STAGES-1:0] sync;
    logic [SYNC_STAGES-1:0] next_sync;
    logic int_rst_n;

    always_comb begin
        next_sync = {sync[SYNC_STAGES-2:0], 1'b1};
    end

    // asserts with the pin, releases on the clock
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync <= '0;
        end else begin
            sync <= next_sync;
        end
    end
    assign int_rst_n = sync[SYNC_STAGES-1];

    // =========================================================
    // post-release counter for agents
    logic [4:0] agent_cnt;
    logic [4:0] next_agent_cnt;
    logic agents_ok;
    always_comb begin
        next_agent_cnt = agent_cnt;
        if (agent_cnt != 5'(AGENT_WAIT_CYC)) begin
            next_agent_cnt = agent_cnt + 5'h01;
        end
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            agent_cnt <= '0;
        end else begin
            agent_cnt <= next_agent_cnt;
        end
    end
    // status only: transactions before this are the agents' fault
    assign agents_ok = (agent_cnt == 5'(AGENT_WAIT_CYC));

    // =========================================================
    // reset-time enables
    logic oe_reg;
    logic next_oe_reg;
    always_comb begin
        next_oe_reg = !reset_n_i;
    end
    // set on the clock during reset; the pin itself gates the output so
    // release is immediate, not after the synchroniser
    always_ff @(posedge clk_i) begin
        oe_reg <= next_oe_reg;
    end
    logic in_reset;
    assign in_reset = !reset_n_i || !int_rst_n;

    // =========================================================
    // pin states
    always_comb begin
        cache_data_out_en_ctl_o = 1'b0;
        tag_out_en_ctl_o = 1'b0;
        mem_bus_drive_ctl_o = 1'b0;
        core_out_o = 1'b0;
        core_bus_oe_o = 1'b0;
        if (!reset_n_i) begin
            cache_data_out_en_ctl_o = oe_reg;
            tag_out_en_ctl_o = oe_reg;
            mem_bus_drive_ctl_o = 1'b1;
        end else if (int_rst_n) begin
            core_out_o = core_out_i;
            core_bus_oe_o = core_bus_drive_i;
        end
        // else: output deasserted, buses tristated until internal release
        if (in_reset) begin
            core_out_o = 1'b0;
            core_bus_oe_o = 1'b0;
        end
        // float-all wins over everything; combinational so that its
        // release restores whatever reset state is current
        cache_data_out_en_ctl_oe_o = float_all_n_i;
        tag_out_en_ctl_oe_o = float_all_n_i;
        mem_bus_drive_ctl_oe_o = float_all_n_i;
        core_out_oe_o = float_all_n_i;
        if (!float_all_n_i) begin
            core_bus_oe_o = 1'b0;
        end
    end

    // =========================================================
    // refresh
    crst_ref_if ref_b ();
    logic [7:0] ref_cnt;
    logic [7:0] next_ref_cnt;
    assign ref_b.run = int_rst_n;
    assign ref_b.force_req = force_ref_i;
    assign ref_b.interval = ref_interval_i;

    crst_ref_timer u_ref (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ref_b(ref_b)
    );

    // counting lets software see when eight refreshes passed
    always_comb begin
        next_ref_cnt = ref_cnt;
        if (ref_b.ref_pulse && ref_cnt != 8'hFF) begin
            next_ref_cnt = ref_cnt + 8'h01;
        end
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref_cnt <= 8'h00;
        end else begin
            ref_cnt <= next_ref_cnt;
        end
    end

    // =========================================================
    // presence detect: load, then shift PD_LEN bits
    crst_pd_state_t pd_state;
    crst_pd_state_t next_pd_state;
    logic [7:0] pd_cnt;
    logic [7:0] next_pd_cnt;
    logic [PD_BITS-1:0] pd_val;
    logic [PD_BITS-1:0] next_pd_val;
    logic pd_clk;
    logic next_pd_clk;

    always_comb begin
        next_pd_state = pd_state;
        next_pd_cnt = pd_cnt;
        next_pd_val = pd_val;
        next_pd_clk = 1'b0;
        case (pd_state)
            CRST_PD_IDLE: begin
                if (int_rst_n) begin
                    next_pd_state = CRST_PD_SHIFT;
                    next_pd_cnt = PD_CNT_RESET;
                end
            end
            CRST_PD_SHIFT: begin
                next_pd_clk = !pd_clk;
                if (pd_clk) begin
                    next_pd_val = {pd_val[PD_BITS-2:0], pd_data_i};
                    next_pd_cnt = pd_cnt + 8'h01;
                    if (pd_cnt == 8'(PD_LEN - 1)) begin
                        next_pd_state = CRST_PD_DONE;
                    end
                end
            end
            CRST_PD_DONE: begin
                next_pd_state = CRST_PD_DONE;
            end
            default: begin
                next_pd_state = CRST_PD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pd_state <= CRST_PD_IDLE;
            pd_cnt <= PD_CNT_RESET;
            pd_val <= '0;
            pd_clk <= 1'b0;
        end else begin
            pd_state <= next_pd_state;
            pd_cnt <= next_pd_cnt;
            pd_val <= next_pd_val;
            pd_clk <= next_pd_clk;
        end
    end

    // =========================================================
    // outputs
    assign int_reset_n_o = int_rst_n;
    assign agents_ok_o = agents_ok;
    assign refresh_o = ref_b.ref_pulse;
    assign force_ref_busy_o = ref_b.force_busy;
    assign refresh_count_o = ref_cnt;
    assign pd_clk_o = pd_clk && float_all_n_i;
    // load strobe low while waiting for release, then high
    assign pd_load_n_o = (pd_state != CRST_PD_IDLE) || !float_all_n_i;
    assign pd_done_o = (pd_state == CRST_PD_DONE);
    assign pd_value_o = pd_val;

    // =========================================================
    // checks
    sequence s_release;
        !int_rst_n ##1 int_rst_n;
    endsequence

    property p_rel_sync;
        @(posedge clk_i) $rose(reset_n_i) |-> !int_rst_n;
    endproperty
    a_rel_sync: assert property (p_rel_sync)
        else $error("internal reset released with the pin");

    property p_rel_time;
        @(posedge clk_i) disable iff (!reset_n_i)
        $rose(reset_n_i) |-> ##1 !int_rst_n ##1 int_rst_n;
    endproperty
    a_rel_time: assert property (p_rel_time)
        else $error("internal reset release late");

    property p_oe_reset;
        @(posedge clk_i) (!reset_n_i ##1 !reset_n_i)
        |-> cache_data_out_en_ctl_o && tag_out_en_ctl_o;
    endproperty
    a_oe_reset: assert property (p_oe_reset)
        else $error("cache enables not asserted in reset");

    property p_oe_drop;
        @(posedge clk_i) reset_n_i |-> !cache_data_out_en_ctl_o &&
            !tag_out_en_ctl_o;
    endproperty
    a_oe_drop: assert property (p_oe_drop)
        else $error("cache enables held after pin release");

    property p_mem_drive;
        @(posedge clk_i) !reset_n_i |-> mem_bus_drive_ctl_o;
    endproperty
    a_mem_drive: assert property (p_mem_drive)
        else $error("memory drive low in reset");

    property p_quiet;
        @(posedge clk_i) (!reset_n_i || !int_rst_n) |->
            !core_out_o && !core_bus_oe_o;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("output active in reset");

    property p_float;
        @(posedge clk_i) !float_all_n_i |-> !core_bus_oe_o &&
            !cache_data_out_en_ctl_oe_o && !mem_bus_drive_ctl_oe_o;
    endproperty
    a_float: assert property (p_float)
        else $error("pin driven under float-all");

    property p_pd_start;
        @(posedge clk_i) disable iff (!reset_n_i)
        s_release |=> pd_state == CRST_PD_SHIFT;
    endproperty
    a_pd_start: assert property (p_pd_start)
        else $error("presence detect not started");

    property p_ref_start;
        @(posedge clk_i) disable iff (!reset_n_i)
        (s_release ##0 ref_interval_i == IVL_RESET && !force_ref_i)
        |-> ##32 refresh_o;
    endproperty
    a_ref_start: assert property (p_ref_start)
        else $error("first refresh not on time");
endmodule
`default_nettype wire

// ==== bench/crst_pd_model.sv ====
// presence-detect serial source facing the reset block
`timescale 1ns/10ps
`default_nettype none
module crst_pd_model #(
    parameter logic [7:0] PATTERN = 8'ha5
) (
    // clock
    input wire logic clk_i,
    // serial link
    input wire logic pd_clk_i,
    input wire logic pd_load_n_i,
    output logic pd_data_o
);
    logic [7:0] sh = 8'h00;
    logic [3:0] cnt = 4'h0;
    logic last = 1'b0;
    // =========================================================
    // shift out msb first, one bit per sampled pd clock high
    always @(posedge clk_i) begin
        if (!pd_load_n_i) begin
            sh <= PATTERN;
            cnt <= 4'h0;
        end else if (pd_clk_i && cnt < 4'h8) begin
            last <= sh[7];
            sh <= {sh[6:0], 1'b0};
            cnt <= cnt + 4'h1;
        end
    end
    // idle line shows the inverse of the last bit so stale samples show
    assign pd_data_o = (pd_load_n_i && cnt < 4'h8) ? sh[7] : ~last;
endmodule
`default_nettype wire

// ==== bench/test_crst_reset_init.sv ====
// self-checking bench of the reset and init block
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("BAD %s exp %0h got %0h", what, exp, got); \
        end \
    end
module test_crst_reset_init;
    import crst_pkg::*;
    localparam logic [7:0] PAT = 8'h5c;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic float_all_n_i = 1'b1;
    logic [IVL_W-1:0] ref_interval_i = IVL_RESET;
    logic force_ref_i = 1'b0;
    logic core_out_i = 1'b0;
    logic core_bus_drive_i = 1'b0;
    logic pd_data_i;
    logic force_ref_busy_o, refresh_o, int_reset_n_o, agents_ok_o;
    logic cd_en, tg_en, cd_oe, tg_oe, mb_drv, mb_oe;
    logic core_out_o, core_out_oe_o, core_bus_oe_o;
    logic pd_clk_o, pd_load_n_o, pd_done_o;
    logic [7:0] refresh_count_o;
    logic [PD_BITS-1:0] pd_value_o;
    int num_errors = 0;
    int cmp_count = 0;
    crst_reset_init crst_reset_init_i (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .float_all_n_i(float_all_n_i),
        .ref_interval_i(ref_interval_i), .force_ref_i(force_ref_i),
        .force_ref_busy_o(force_ref_busy_o), .refresh_o(refresh_o),
        .refresh_count_o(refresh_count_o), .int_reset_n_o(int_reset_n_o),
        .agents_ok_o(agents_ok_o), .cache_data_out_en_ctl_o(cd_en),
        .tag_out_en_ctl_o(tg_en), .cache_data_out_en_ctl_oe_o(cd_oe),
        .tag_out_en_ctl_oe_o(tg_oe), .mem_bus_drive_ctl_o(mb_drv),
        .mem_bus_drive_ctl_oe_o(mb_oe), .core_out_i(core_out_i),
        .core_bus_drive_i(core_bus_drive_i), .core_out_o(core_out_o),
        .core_out_oe_o(core_out_oe_o), .core_bus_oe_o(core_bus_oe_o),
        .pd_data_i(pd_data_i), .pd_clk_o(pd_clk_o),
        .pd_load_n_o(pd_load_n_o), .pd_done_o(pd_done_o),
        .pd_value_o(pd_value_o)
    );
    crst_pd_model #(.PATTERN(PAT)) crst_pd_model_i (
        .clk_i(clk_i), .pd_clk_i(pd_clk_o), .pd_load_n_i(pd_load_n_o),
        .pd_data_o(pd_data_i)
    );
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // =========================================================
    // helpers
    task automatic settle();
        @(posedge clk_i);
        #1;
    endtask
    task automatic conclude();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // =========================================================
    // scenarios
    task automatic reset_pins();
        `CHK("int_rst", 1'b0, int_reset_n_o)
        `CHK("core_out", 1'b0, core_out_o)
        `CHK("refresh", 1'b0, refresh_o)
        `CHK("bus_oe", 1'b0, core_bus_oe_o)
        `CHK("cd_en", 1'b1, cd_en)
        `CHK("tg_en", 1'b1, tg_en)
        `CHK("mb_drv", 1'b1, mb_drv)
        `CHK("cd_oe", 1'b1, cd_oe)
    endtask
    task automatic float_in_reset();
        @(posedge clk_i) float_all_n_i <= 1'b0;
        #1;
        `CHK("fl_cd", 1'b0, cd_oe)
        `CHK("fl_tg", 1'b0, tg_oe)
        `CHK("fl_mb", 1'b0, mb_oe)
        `CHK("fl_co", 1'b0, core_out_oe_o)
        `CHK("fl_bus", 1'b0, core_bus_oe_o)
        @(posedge clk_i) float_all_n_i <= 1'b1;
        #1;
        `CHK("unfl_mb", 1'b1, mb_oe)
        reset_pins();
    endtask
    // release reset, then time the first refresh from internal release
    task automatic release_and_refresh(input int period);
        int n;
        @(posedge clk_i) reset_n_i <= 1'b1;
        #1;
        `CHK("rel_cd", 1'b0, cd_en)
        `CHK("rel_tg", 1'b0, tg_en)
        `CHK("rel_int", 1'b0, int_reset_n_o)
        settle();
        `CHK("int_e1", 1'b0, int_reset_n_o)
        settle();
        `CHK("int_e2", 1'b1, int_reset_n_o)
        `CHK("agents_e", 1'b0, agents_ok_o)
        n = 0;
        while (n < 300 && refresh_o !== 1'b1) begin
            settle();
            n++;
        end
        `CHK("first_ref", period, n)
        `CHK("agents", 1'b1, agents_ok_o)
        `CHK("pd_done", 1'b1, pd_done_o)
        `CHK("pd_val", PAT, pd_value_o)
    endtask
    task automatic normal_traffic();
        int n;
        n = 0;
        // memory use waits for eight refreshes after reset
        while (n < 400 && refresh_count_o < 8'h08) begin
            settle();
            n++;
        end
        `CHK("ref8", 1'b1, refresh_count_o >= 8'h08)
        // scrubbing memory check bits is left to software
        @(posedge clk_i) core_out_i <= 1'b1;
        core_bus_drive_i <= 1'b1;
        settle();
        settle();
        `CHK("core_out", 1'b1, core_out_o)
        `CHK("bus_oe", 1'b1, core_bus_oe_o)
    endtask
    task automatic periodic(input logic [7:0] ivl);
        int n;
        @(posedge clk_i) ref_interval_i <= ivl;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            settle();
            while (n < 300 && refresh_o !== 1'b1) begin
                settle();
                n++;
            end
        end
        `CHK("period", 32 * ivl - 1, n)
    endtask
    task automatic force_one();
        logic [7:0] c0;
        c0 = refresh_count_o;
        @(posedge clk_i) force_ref_i <= 1'b1;
        settle();
        `CHK("busy", 1'b1, force_ref_busy_o)
        `CHK("no_ref", 1'b0, refresh_o)
        // still high here while busy: must be ignored
        @(posedge clk_i) force_ref_i <= 1'b0;
        #1;
        `CHK("f_ref", 1'b1, refresh_o)
        `CHK("clr", 1'b0, force_ref_busy_o)
        repeat (3) settle();
        `CHK("f_cnt", c0 + 8'h01, refresh_count_o)
    endtask
    task automatic force_pair();
        while (refresh_o !== 1'b1) begin
            settle();
        end
        // let the periodic pulse be counted before the baseline is taken
        settle();
        force_one();
        force_one();
    endtask
    task automatic midrun_reset();
        @(posedge clk_i) reset_n_i <= 1'b0;
        core_out_i <= 1'b0;
        core_bus_drive_i <= 1'b0;
        #1;
        `CHK("async_int", 1'b0, int_reset_n_o)
        `CHK("mid_mb", 1'b1, mb_drv)
        settle();
        reset_pins();
        repeat (10) settle();
    endtask
    // =========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        #1;
        reset_pins();
        float_in_reset();
        repeat (POWERUP_CYC) settle();
        release_and_refresh(32);
        normal_traffic();
        periodic(8'h02);
        force_pair();
        midrun_reset();
        release_and_refresh(64);
        conclude();
    end
    initial begin
        repeat (4000) @(posedge clk_i);
        num_errors++;
        conclude();
    end
endmodule
`default_nettype wire
